// ---- hdl/module_clock_gate_divider.sv ----
// module clock control: register slave, gating, shutdown and divider
// Operation
// - debug-halt-allow changes only with suspend_write_mask in the write
// - fast_switch_off_enable is guarded by the same write mask
// - setting disable_request_bit starts the shutdown of the peripheral
// - an honoured sleep request also starts the shutdown
// - secure shutdown stops orderly; disabled status then shows off
// - bus side acknowledges only after the current transfer has ended
// - secure shutdown gates the clock only after both acknowledges
// - fast switch-off enable zero selects secure shutdown
// - fast switch-off enable one gates once the bus side is idle
// - this build may ignore the kernel acknowledge whatever the bit says
// - run divider field is 8 or 2 bits, inside the bus side
// - a zero divider switches the module clock off
// - nonzero divider gives module clock of system clock over divider
// - kernel reads wait for a module tick; slower clock, longer read
// - divider and bus-side shutdown live together in the bus side
// - disable request at bit 0, read-write, one requests disable
// - sleep_ignore_bit one ignores sleep; zero lets sleep stop the clock
// - debug-halt-allow one stops the module under suspend; zero ignores
// - suspend write mask is write-only, never stored, reads zero
`timescale 1ns/1ns
module module_clock_gate_divider #(
  parameter int ADDR_W = clk_ctrl_pkg::AXI_ADDR_W,
  parameter int RMC_W = clk_ctrl_pkg::RMC_FIELD_W,
  parameter bit ALWAYS_FAST = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [clk_ctrl_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [clk_ctrl_pkg::AXI_DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [clk_ctrl_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_req,
  input wire logic suspend_req,
  input wire logic kernel_ack,
  input wire logic [clk_ctrl_pkg::AXI_DATA_W-1:0] krd_data,
  output logic mod_clk_en,
  output logic shutdown_req,
  output logic module_disabled,
  output logic krd_strobe
);
  import clk_ctrl_pkg::*;

  if (!(RMC_W == 8 || RMC_W == 2)) begin : g_bad_rmc
    $error("divider width must be 8 or 2");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("address width too small for the map");
  end

  function automatic reg_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    if (w == ADDR_W'(CLC_OFS)) reg_sel = SEL_CLC;
    else if (w == ADDR_W'(KDATA_OFS)) reg_sel = SEL_KDATA;
    else reg_sel = SEL_NONE;
  endfunction : reg_sel

  clk_ctl_if #(.RMC_W(RMC_W)) cc ();

  // control bits
  logic disable_request_bit_r;
  logic debug_halt_allow_r;
  logic sleep_ignore_bit_r;
  logic fast_switch_off_enable_r;
  logic [RMC_W-1:0] rmc_r;
  logic disabled_status_bit_now;
  logic [7:0] rmc_field;
  logic [AXI_DATA_W-1:0] clc_word;

  // write channel state
  logic awready_r;
  logic wready_r;
  logic aw_have_r;
  logic w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [AXI_DATA_W-1:0] wdata_r;
  logic [AXI_DATA_W/8-1:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_hs;
  logic w_hs;
  logic wr_do;
  logic wr_clc;

  // read channel state
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [AXI_DATA_W-1:0] rdata_r;
  logic rd_busy_r;
  logic rd_clc_r;
  logic krd_strobe_r;
  logic disabled_status_bit_r;
  logic ar_hs;
  logic rd_done;

  assign aw_hs = s_axi_awvalid && awready_r;
  assign w_hs = s_axi_wvalid && wready_r;
  assign wr_do = aw_have_r && w_have_r && !bvalid_r;
  assign wr_clc = wr_do && reg_sel(awaddr_r) == SEL_CLC;
  assign ar_hs = s_axi_arvalid && arready_r;

  // disable sources: software, honoured sleep, enabled suspend
  assign cc.dis_cond = disable_request_bit_r
    || (sleep_req && !sleep_ignore_bit_r)
    || (suspend_req && debug_halt_allow_r);
  // secure unless fast is chosen or this build forces it;
  // forcing fast trades an orderly kernel stop for the quickest halt
  assign cc.fast = fast_switch_off_enable_r || ALWAYS_FAST;
  // bus side is idle once no kernel read is in flight
  assign cc.bus_idle = !rd_busy_r;
  assign cc.kernel_ack = kernel_ack;
  assign cc.run_divider_field = rmc_r;
  assign cc.run = !cc.off && rmc_r != '0;

  shutdown_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .s(cc.fsm)
  );

  run_divider #(.RMC_W(RMC_W)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(cc.div)
  );

  // disabled status follows the gated state or a zero divider
  assign disabled_status_bit_now = cc.off || rmc_r == '0;
  assign rmc_field = 8'(rmc_r);
  always_comb begin
    clc_word = '0;
    clc_word[DISABLE_REQUEST_BIT_BIT] = disable_request_bit_r;
    clc_word[DISABLED_STATUS_BIT_BIT] = disabled_status_bit_now;
    clc_word[DEBUG_HALT_ALLOW_BIT] = debug_halt_allow_r;
    clc_word[SLEEP_IGNORE_BIT_BIT] = sleep_ignore_bit_r;
    clc_word[FAST_SWITCH_OFF_ENABLE_BIT] = fast_switch_off_enable_r;
    clc_word[RMC_LSB +: 8] = rmc_field;
    // mask bit is never stored, so it always reads zero
  end

  // configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disable_request_bit_r <= DISABLE_REQUEST_BIT_RST;
      debug_halt_allow_r <= DEBUG_HALT_ALLOW_RST;
      sleep_ignore_bit_r <= SLEEP_IGNORE_BIT_RST;
      fast_switch_off_enable_r <= FAST_SWITCH_OFF_ENABLE_RST;
      rmc_r <= RMC_W'(RMC_RST);
    end else if (wr_clc) begin
      if (wstrb_r[0]) begin
        disable_request_bit_r <= wdata_r[DISABLE_REQUEST_BIT_BIT];
        sleep_ignore_bit_r <= wdata_r[SLEEP_IGNORE_BIT_BIT];
        // debug-only bits: an application write without the mask
        // cannot disturb what a debugger set
        if (wdata_r[SUSPEND_WRITE_MASK_BIT]) begin
          debug_halt_allow_r <= wdata_r[DEBUG_HALT_ALLOW_BIT];
          fast_switch_off_enable_r <= wdata_r[FAST_SWITCH_OFF_ENABLE_BIT];
        end
      end
      if (wstrb_r[1]) rmc_r <= wdata_r[RMC_LSB +: RMC_W];
    end
  end

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
    end else if (aw_hs) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_have_r <= 1'b0;
    end else if (!aw_have_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (w_hs) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_do) begin
      w_have_r <= 1'b0;
    end else if (!w_have_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  // the kernel data window is read-only, so a write there errors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_clc ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // kernel read ends on a module clock tick, or at once when stopped
  assign rd_done = rd_busy_r && (cc.tick || !cc.run);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rd_busy_r <= 1'b0;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rd_busy_r <= reg_sel(s_axi_araddr) == SEL_KDATA;
    end else if (rd_done) begin
      rd_busy_r <= 1'b0;
    end else if (!rd_busy_r && !rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
      rd_clc_r <= 1'b0;
    end else if (ar_hs && reg_sel(s_axi_araddr) != SEL_KDATA) begin
      rvalid_r <= 1'b1;
      rd_clc_r <= reg_sel(s_axi_araddr) == SEL_CLC;
      if (reg_sel(s_axi_araddr) == SEL_CLC) begin
        rresp_r <= RESP_OKAY;
        rdata_r <= clc_word;
      end else begin
        rresp_r <= RESP_SLVERR;
        rdata_r <= '0;
      end
    end else if (rd_done) begin
      rvalid_r <= 1'b1;
      rd_clc_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= krd_data;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // side effects of a read apply only with a running module clock;
  // a stopped module sees a plain, harmless read
  always_ff @(posedge aclk) begin
    if (!aresetn) krd_strobe_r <= 1'b0;
    else krd_strobe_r <= rd_done && cc.tick;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) disabled_status_bit_r <= 1'b1;
    else disabled_status_bit_r <= disabled_status_bit_now;
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign mod_clk_en = cc.tick;
  assign shutdown_req = cc.req;
  assign module_disabled = disabled_status_bit_r;
  assign krd_strobe = krd_strobe_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_debug_halt_allow_guarded: assert property (
    wr_clc && !(wstrb_r[0] && wdata_r[SUSPEND_WRITE_MASK_BIT]) |=> $stable(debug_halt_allow_r))
    else $error("halt-allow changed without mask");
  a_fast_switch_off_enable_guarded: assert property (
    wr_clc && wstrb_r[0] && wdata_r[SUSPEND_WRITE_MASK_BIT]
    |=> fast_switch_off_enable_r == $past(wdata_r[FAST_SWITCH_OFF_ENABLE_BIT]))
    else $error("fast switch-off not taken with mask");
  a_mask_reads_zero: assert property (
    rvalid_r && rd_clc_r |-> !rdata_r[SUSPEND_WRITE_MASK_BIT])
    else $error("mask bit read back nonzero");
  a_disable_starts: assert property (
    disable_request_bit_r && !cc.off |=> shutdown_req)
    else $error("disable request did not start shutdown");
  a_sleep_honoured: assert property (
    sleep_req && !sleep_ignore_bit_r && !cc.off |=> shutdown_req)
    else $error("honoured sleep did not start shutdown");
  a_clock_off_zero: assert property (
    rmc_r == '0 ##1 rmc_r == '0 |-> !mod_clk_en)
    else $error("module clock ran with zero divider");
  a_restore_clock: assert property (
    cc.off && !cc.dis_cond && rmc_r != '0 |=> !cc.off ##1 !module_disabled)
    else $error("clock not restored after enable");
  a_read_waits: assert property (
    rd_busy_r && !cc.tick && cc.run |=> !rvalid_r && !krd_strobe_r)
    else $error("kernel read ended without module clock");
  a_bus_idle_gate: assert property (
    rd_busy_r && !cc.off |=> !cc.off)
    else $error("clock gated during a bus transfer");
  a_disabled_status_bit_follows: assert property (
    1'b1 |=> module_disabled == $past(disabled_status_bit_now))
    else $error("disabled status does not follow the gate");

  c_mask_write: cover property (wr_clc && wdata_r[SUSPEND_WRITE_MASK_BIT]);
  c_kernel_read: cover property (rd_done && cc.tick ##1 krd_strobe_r);
  c_restore: cover property (cc.off ##1 !cc.off ##[1:20] mod_clk_en);
  c_secure_wait: cover property (
    !cc.fast && shutdown_req && !kernel_ack ##1 kernel_ack);
endmodule : module_clock_gate_divider

// ---- hdl/clk_ctrl_pkg.sv ----
// shared constants and types of the module clock control block
package clk_ctrl_pkg;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_ADDR_W = 8;
  localparam int RMC_FIELD_W = 8;
  // register byte offsets
  localparam logic [7:0] CLC_OFS = 8'h00;
  localparam logic [7:0] KDATA_OFS = 8'h04;
  // field positions in the clock control word
  localparam int DISABLE_REQUEST_BIT_BIT = 0;
  localparam int DISABLED_STATUS_BIT_BIT = 1;
  localparam int DEBUG_HALT_ALLOW_BIT = 2;
  localparam int SLEEP_IGNORE_BIT_BIT = 3;
  localparam int SUSPEND_WRITE_MASK_BIT = 4;
  localparam int FAST_SWITCH_OFF_ENABLE_BIT = 5;
  localparam int RMC_LSB = 8;
  // reset values: the module comes up disabled
  localparam logic DISABLE_REQUEST_BIT_RST = 1'h1;
  localparam logic DEBUG_HALT_ALLOW_RST = 1'h0;
  localparam logic SLEEP_IGNORE_BIT_RST = 1'h0;
  localparam logic FAST_SWITCH_OFF_ENABLE_RST = 1'h0;
  localparam logic [7:0] RMC_RST = 8'h01;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DRAIN = 2'b01,
    ST_OFF = 2'b10
  } shut_state_e;
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CLC = 2'b01,
    SEL_KDATA = 2'b10
  } reg_sel_e;
endpackage : clk_ctrl_pkg

// ---- hdl/clk_ctl_if.sv ----
// signals between the control top, the shutdown sequencer and the divider
`timescale 1ns/1ns
interface clk_ctl_if #(parameter int RMC_W = 8);
  logic dis_cond;
  logic fast;
  logic bus_idle;
  logic kernel_ack;
  logic req;
  logic off;
  logic run;
  logic [RMC_W-1:0] run_divider_field;
  logic tick;
  modport top (output dis_cond, output fast, output bus_idle,
    output kernel_ack, output run, output run_divider_field,
    input req, input off, input tick);
  modport fsm (input dis_cond, input fast, input bus_idle,
    input kernel_ack, output req, output off);
  modport div (input run, input run_divider_field, output tick);
endinterface : clk_ctl_if

// ---- hdl/shutdown_seq.sv ----
// shutdown handshake sequencer: run, drain, off
`timescale 1ns/1ns
module shutdown_seq (
  input wire logic aclk,
  input wire logic aresetn,
  clk_ctl_if.fsm s
);
  import clk_ctrl_pkg::*;

  shut_state_e state_r;
  shut_state_e state_nxt;
  logic req_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (s.dis_cond) state_nxt = ST_DRAIN;
      end
      ST_DRAIN: begin
        // a withdrawn request aborts the drain, clock never stopped
        if (!s.dis_cond) state_nxt = ST_RUN;
        else if (s.bus_idle && (s.fast || s.kernel_ack))
          state_nxt = ST_OFF;
      end
      ST_OFF: begin
        if (!s.dis_cond) state_nxt = ST_RUN;
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state_r <= ST_OFF;
    else state_r <= state_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) req_r <= 1'b1;
    else req_r <= (state_nxt != ST_RUN);
  end

  assign s.req = req_r;
  assign s.off = (state_r == ST_OFF);

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_no_early_gate: assert property (
    state_r == ST_DRAIN && !(s.bus_idle && (s.fast || s.kernel_ack))
    |=> state_r != ST_OFF)
    else $error("clock gated before acknowledges");
  a_fast_gate: assert property (
    state_r == ST_DRAIN && s.dis_cond && s.bus_idle && s.fast
    |=> state_r == ST_OFF)
    else $error("fast switch-off did not gate");
  a_off_holds: assert property (
    state_r == ST_OFF && s.dis_cond |=> state_r == ST_OFF && req_r)
    else $error("gated state left while disabled");
  c_drain_off: cover property (
    state_r == ST_RUN ##1 state_r == ST_DRAIN [*2] ##1 state_r == ST_OFF);
endmodule : shutdown_seq

// ---- hdl/run_divider.sv ----
// run-mode divider: one tick every rmc system clocks
`timescale 1ns/1ns
module run_divider #(
  parameter int RMC_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  clk_ctl_if.div d
);
  logic [RMC_W-1:0] cnt_r;
  logic tick_r;
  logic wrap;

  assign wrap = (cnt_r >= d.run_divider_field - RMC_W'(1));

  // zero divider means no tick at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (!d.run || d.run_divider_field == '0) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (wrap) begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + RMC_W'(1);
      tick_r <= 1'b0;
    end
  end

  assign d.tick = tick_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_div_period: assert property (
    tick_r && d.run && d.run_divider_field == RMC_W'(2) ##1 d.run && d.run_divider_field == RMC_W'(2)
    |-> !tick_r ##1 tick_r)
    else $error("divide by two period wrong");
endmodule : run_divider

// ---- tb/kernel_model.sv ----
// partner model: peripheral kernel with stable-state acknowledge and data
`timescale 1ns/1ns
module kernel_model #(
  parameter logic [31:0] DATA_BASE = 32'h5A00_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic shutdown_req,
  input wire logic krd_strobe,
  output logic kernel_ack,
  output logic [31:0] krd_data
);
  logic [3:0] wait_r;

  // slow mode stands for a kernel still finishing its own transfer
  always_ff @(posedge aclk) begin
    if (!aresetn || !shutdown_req) begin
      wait_r <= 4'h0;
      kernel_ack <= 1'b0;
    end else begin
      if (wait_r != 4'hF) begin
        wait_r <= wait_r + 4'h1;
      end
      kernel_ack <= (wait_r >= (slow ? 4'h7 : 4'h0));
    end
  end

  // a consuming read moves the data on, so a repeated read differs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      krd_data <= DATA_BASE;
    end else if (krd_strobe) begin
      krd_data <= krd_data + 32'h1;
    end
  end
endmodule : kernel_model

// ---- tb/tb_module_clock_gate_divider.sv ----
// testbench of the module clock control block
`timescale 1ns/1ns
module tb_module_clock_gate_divider;
  import clk_ctrl_pkg::*;
  localparam logic [31:0] KBASE = 32'h5A00_0000;
  logic aclk, aresetn, slow, sleep_req, suspend_req, kernel_ack;
  logic [7:0] awaddr, araddr, run_divider_field;
  logic [31:0] wdata, rdata, krd_data;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic mod_clk_en, shutdown_req, module_disabled, krd_strobe;
  logic [33:0] wq[$];
  logic [33:0] rq[$];
  int err_total, cmp_count, seed, n, strb_n, i;

  module_clock_gate_divider #(.ALWAYS_FAST(1'b0)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_req(sleep_req), .suspend_req(suspend_req),
    .kernel_ack(kernel_ack), .krd_data(krd_data), .mod_clk_en(mod_clk_en),
    .shutdown_req(shutdown_req), .module_disabled(module_disabled),
    .krd_strobe(krd_strobe));

  kernel_model #(.DATA_BASE(KBASE)) partner (
    .aclk(aclk), .aresetn(aresetn), .slow(slow),
    .shutdown_req(shutdown_req), .krd_strobe(krd_strobe),
    .kernel_ack(kernel_ack), .krd_data(krd_data));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // tasks start and end just after a rising edge; handshakes are seen at
  // the falling edge so the taking edge is known without a race
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw_go, w_go, b_go;
    wq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_go = 1'b0;
    for (int k = 0; k < 100 && !b_go; k++) begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid && bready;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_go) begin
      err_total++;
      stop_test();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ar_go, r_go;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_go = 1'b0;
    for (int k = 0; k < 100 && !r_go; k++) begin
      @(negedge aclk);
      ar_go = arvalid && arready;
      r_go = rvalid && rready;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_go) begin
      err_total++;
      stop_test();
    end
  endtask : rd

  task automatic wait_dis(input logic lvl);
    n = 0;
    while (n < 600) begin
      @(negedge aclk);
      if (module_disabled === lvl) break;
      n++;
    end
    check(34'(module_disabled), 34'(lvl));
    @(posedge aclk);
    if (n >= 600) stop_test();
  endtask : wait_dis

  task automatic pulses(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(negedge aclk);
      if (mod_clk_en === 1'b1) n++;
    end
    @(posedge aclk);
  endtask : pulses

  always @(negedge aclk) begin
    if (bvalid === 1'b1 && bready)
      check({bresp, 32'h0}, wq.pop_front());
    if (rvalid === 1'b1 && rready)
      check({rresp, rdata}, rq.pop_front());
    if (krd_strobe === 1'b1) strb_n++;
  end

  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {slow, sleep_req, suspend_req, aresetn} = '0;
    seed = 16580;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    check(34'({shutdown_req, module_disabled, mod_clk_en}), 34'h6);
    @(posedge aclk);
    rd(8'h00, 32'h0000_0103, RESP_OKAY);
    rd(8'h08, 32'h0, RESP_SLVERR);
    wr(8'h04, 32'h1, RESP_SLVERR);
    // divider sweep: two fixed values then random ones, fresh start each
    for (i = 0; i < 5; i++) begin
      run_divider_field = (i < 2) ? 8'(i + 1) : 8'($random(seed));
      if (run_divider_field == 8'h00) run_divider_field = 8'h01;
      wr(8'h00, {16'h0, run_divider_field, 8'h01}, RESP_OKAY);
      wait_dis(1'b1);
      wr(8'h00, {16'h0, run_divider_field, 8'h00}, RESP_OKAY);
      wait_dis(1'b0);
      pulses(4 * run_divider_field);
      check(34'(n), 34'h4);
    end
    wr(8'h00, 32'h0, RESP_OKAY);
    pulses(20);
    check(34'(n), 34'h0);
    rd(8'h00, 32'h0000_0002, RESP_OKAY);
    // debug-only bits refuse a write without the mask
    wr(8'h00, 32'h0000_0124, RESP_OKAY);
    wait_dis(1'b0);
    rd(8'h00, 32'h0000_0100, RESP_OKAY);
    wr(8'h00, 32'h0000_0134, RESP_OKAY);
    rd(8'h00, 32'h0000_0124, RESP_OKAY);
    slow <= 1'b1;
    suspend_req <= 1'b1;
    wait_dis(1'b1);
    check(34'(n > 6), 34'h0);
    suspend_req <= 1'b0;
    wait_dis(1'b0);
    wr(8'h00, 32'h0000_0114, RESP_OKAY);
    suspend_req <= 1'b1;
    wait_dis(1'b1);
    check(34'(n > 6), 34'h1);
    pulses(20);
    check(34'(n), 34'h0);
    suspend_req <= 1'b0;
    wait_dis(1'b0);
    wr(8'h00, 32'h0000_0110, RESP_OKAY);
    suspend_req <= 1'b1;
    pulses(20);
    check(34'(n), 34'h14);
    suspend_req <= 1'b0;
    sleep_req <= 1'b1;
    wait_dis(1'b1);
    sleep_req <= 1'b0;
    wait_dis(1'b0);
    wr(8'h00, 32'h0000_0108, RESP_OKAY);
    sleep_req <= 1'b1;
    pulses(20);
    check(34'(n), 34'h14);
    sleep_req <= 1'b0;
    // consuming reads through a divided clock, then a plain one while off
    wr(8'h00, 32'h0000_0400, RESP_OKAY);
    rd(8'h04, KBASE, RESP_OKAY);
    rd(8'h04, KBASE + 32'h1, RESP_OKAY);
    wr(8'h00, 32'h0000_0401, RESP_OKAY);
    wait_dis(1'b1);
    rd(8'h04, KBASE + 32'h2, RESP_OKAY);
    check(34'(strb_n), 34'h2);
    stop_test();
  end
endmodule : tb_module_clock_gate_divider
